/* i2c_bus_host.sv */
// bus host model driving the two-wire port
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_host
(
  input wire logic clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // quarter period: 65 for fast mode, 250 for standard mode
  int qn = 65;
  task automatic q();
    repeat (qn) @(posedge clk);
  endtask
  task automatic start();
    sda <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda <= 1'b1;
    q();
  endtask
  task automatic bx(input logic b, output logic r);
    sda <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda_bus;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bx(d[i], r[i]);
  endtask
endmodule
`default_nettype wire

/* i2c_port_checker.sv */
// assertions on the two-wire target port pins
`timescale 1ns/1ps
`default_nettype none
module i2c_port_checker
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [7:0] reg_addr,
  input wire logic wr_strobe,
  input wire logic rd_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_od; !sda_oe_n |-> !sda_out; endproperty
  property p_one; !(wr_strobe && rd_strobe); endproperty
  property p_wrp; wr_strobe |=> !wr_strobe; endproperty
  property p_rdp; rd_strobe |=> !rd_strobe; endproperty
  property p_inc;
    (wr_strobe || rd_strobe) |=> reg_addr == $past(reg_addr) + 8'h01;
  endproperty
  property p_sel; !interface_select [*7] |-> sda_oe_n && !wr_strobe; endproperty
  property p_lo; $changed(sda_oe_n) |-> !scl_in; endproperty
  property p_ack; wr_strobe |-> ##[0:8] !sda_oe_n; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  a_one: assert property (p_one) else $error("both strobes");
  a_wrp: assert property (p_wrp) else $error("long wr pulse");
  a_rdp: assert property (p_rdp) else $error("long rd pulse");
  a_inc: assert property (p_inc) else $error("no increment");
  a_sel: assert property (p_sel) else $error("active deselected");
  a_lo: assert property (p_lo) else $error("sda moved, scl high");
  a_ack: assert property (p_ack) else $error("data not acked");
  c_wr: cover property (wr_strobe);
  c_rd: cover property (rd_strobe);
  c_ack: cover property ($fell(sda_oe_n));
endmodule
bind i2c_target_port i2c_port_checker chk (.clk(clk), .rst_n(rst_n),
  .interface_select(interface_select), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_addr(reg_addr),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe));
`default_nettype wire

/* i2c_target_pkg.sv */
// constants for the two-wire target port
package i2c_target_pkg;
  localparam logic [6:0] addr_strap_high = 7'h1d;
  localparam logic [6:0] addr_strap_low = 7'h53;
  localparam int clk_rate_khz = 100000;
  localparam int scl_fast_khz = 400;
  localparam int scl_std_khz = 100;
  localparam int sync_stages = 3;
  localparam logic [3:0] bit_count_reset = 4'h0;
  localparam logic [3:0] bits_per_byte = 4'h8;
  localparam logic [7:0] reg_addr_reset = 8'h00;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_addr_ack = 3'b011,
    st_wr_byte = 3'b010,
    st_wr_ack = 3'b110,
    st_rd_byte = 3'b111,
    st_rd_ack = 3'b101
  } tgt_state_t;
endpackage

/* i2c_target_port.sv */
// two-wire target port giving register read and write access
`timescale 1ns/1ps
`default_nettype none
module i2c_target_port
  import i2c_target_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select,
  input wire logic target_address_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic [7:0] rd_data
);
  logic scl;
  logic sda;
  logic sel;
  logic strap_seen;
  logic scl_d;
  logic sda_d;
  logic [6:0] own_addr;
  tgt_state_t state;
  logic [3:0] bit_count;
  logic [7:0] shift;
  logic [7:0] tx;
  logic first_byte;
  logic host_ack;

  pin_sync u_scl (.clk(clk), .rst_n(rst_n), .pin(scl_in), .level(scl));
  pin_sync u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_in), .level(sda));
  pin_sync u_sel
  (
    .clk(clk), .rst_n(rst_n), .pin(interface_select), .level(sel)
  );
  pin_sync u_strap
  (
    .clk(clk), .rst_n(rst_n), .pin(target_address_strap),
    .level(strap_seen)
  );

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // data held high when deselected is never a start
  wire start_cond = sel & scl & scl_d & sda_d & ~sda;
  wire stop_cond = scl & scl_d & ~sda_d & sda;

  function automatic logic addr_match(input logic [6:0] a,
                                      input logic [6:0] own);
    addr_match = (a == own);
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      own_addr <= addr_strap_high;
    else
      own_addr <= strap_seen ? addr_strap_high : addr_strap_low;
  end

  // target logic runs only while selected
  // sampling at 100 MHz covers both scl rates
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= st_idle;
      bit_count <= bit_count_reset;
      shift <= 8'h00;
      first_byte <= 1'b0;
      host_ack <= 1'b0;
    end
    else if (!sel || stop_cond)
    begin
      state <= st_idle;
      bit_count <= bit_count_reset;
    end
    else if (start_cond)
    begin
      state <= st_addr;
      bit_count <= bit_count_reset;
    end
    else
    begin
      case (state)
        st_idle:
        begin
          bit_count <= bit_count_reset;
        end
        st_addr, st_wr_byte:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda};
            bit_count <= bit_count + 4'h1;
          end
          else if (scl_fall && bit_count == bits_per_byte)
          begin
            bit_count <= bit_count_reset;
            if (state == st_addr)
            begin
              if (addr_match(shift[7:1], own_addr))
              begin
                state <= st_addr_ack;
                first_byte <= ~shift[0];
              end
              else
                state <= st_idle;
            end
            else
              state <= st_wr_ack;
          end
        end
        st_addr_ack:
        begin
          if (scl_fall)
            state <= shift[0] ? st_rd_byte : st_wr_byte;
        end
        st_wr_ack:
        begin
          if (scl_fall)
          begin
            first_byte <= 1'b0;
            state <= st_wr_byte;
          end
        end
        st_rd_byte:
        begin
          if (scl_fall)
          begin
            if (bit_count == bits_per_byte - 4'h1)
            begin
              bit_count <= bit_count_reset;
              state <= st_rd_ack;
            end
            else
              bit_count <= bit_count + 4'h1;
          end
        end
        st_rd_ack:
        begin
          if (scl_rise)
            host_ack <= ~sda;
          else if (scl_fall)
          begin
            // nack ends the read, ack sends another byte
            state <= host_ack ? st_rd_byte : st_idle;
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end

  // first data byte is register address, then data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_addr <= reg_addr_reset;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
    end
    else
    begin
      wr_strobe <= 1'b0;
      if (sel && state == st_wr_byte && scl_fall
          && bit_count == bits_per_byte && !start_cond && !stop_cond)
      begin
        if (first_byte)
          reg_addr <= shift;
        else
        begin
          wr_data <= shift;
          wr_strobe <= 1'b1;
        end
      end
      else if (wr_strobe || rd_strobe)
        reg_addr <= reg_addr + 8'h01;
    end
  end

  // read byte loaded at the end of a read address ack and of each host-acked read ack
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx <= 8'h00;
      rd_strobe <= 1'b0;
    end
    else
    begin
      rd_strobe <= 1'b0;
      if (sel && scl_fall && !start_cond && !stop_cond
          && ((state == st_addr_ack && shift[0])
          || (state == st_rd_ack && host_ack)))
      begin
        tx <= rd_data;
        rd_strobe <= 1'b1;
      end
      else if (state == st_rd_byte && scl_fall)
        tx <= {tx[6:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (state == st_addr_ack || state == st_wr_ack)
    begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b0;
    end
    else if (state == st_rd_byte && !tx[7])
    begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* i2c_target_port_bench.sv */
// self-checking bench for the two-wire target port
`timescale 1ns/1ps
`default_nettype none
module i2c_target_port_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic strap = 1'b1;
  logic scl, sda_h, sda_out, sda_oe_n, wr_strobe, rd_strobe, k;
  logic [7:0] reg_addr, wr_data, rd_data, r, a;
  logic [7:0] mem [256];
  logic [7:0] exp_v [256];
  logic [6:0] own;
  logic [31:0] seed = 32'h34;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  wire logic sda = sda_h & (sda_oe_n | sda_out);
  assign rd_data = mem[reg_addr];
  always #5 clk = ~clk;
  i2c_bus_host h (.clk(clk), .sda_bus(sda), .scl(scl), .sda(sda_h));
  i2c_target_port dut (.clk(clk), .rst_n(rst_n), .interface_select(sel),
    .target_address_strap(strap), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [6:0] own_of(input logic s);
    return s ? 7'h1d : 7'h53;
  endfunction
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic nak);
    h.by(b, r);
    h.bx(1'b1, k);
    chk({7'h00, k}, {7'h00, nak});
  endtask
  task automatic ad(input logic [7:0] b, input logic nak);
    h.start();
    wb(b, nak);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wr_strobe)
      mem[reg_addr] <= wr_data;
    if (cyc == 80000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    foreach (mem[i])
      mem[i] = xs();
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      strap <= s[0];
      own = own_of(s[0]);
      repeat (8) @(posedge clk);
      ad({own ^ 7'h4e, 1'b0}, 1'b1);
      h.stop();
      a = s ? 8'hff : xs();
      n = 1 + s + xs() % 2;
      h.qn = s ? 250 : 65;
      ad({own, 1'b0}, 1'b0);
      h.qn = 65;
      wb(a, 1'b0);
      for (int i = 0; i < n; i++)
      begin
        exp_v[8'(a + i)] = xs();
        wb(exp_v[8'(a + i)], 1'b0);
      end
      h.stop();
      chk(reg_addr, 8'(a + n));
      ad({own, 1'b0}, 1'b0);
      wb(a, 1'b0);
      if (s == 0)
        h.stop();
      ad({own, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++)
      begin
        h.by(8'hff, r);
        chk(r, exp_v[8'(a + i)]);
        h.bx(i == n - 1, k);
      end
      h.stop();
      chk(reg_addr, 8'(a + n));
    end
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    ad({own, 1'b0}, 1'b1);
    h.stop();
    test_done();
  end
endmodule
`default_nettype wire

/* pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import i2c_target_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic [sync_stages-1:0] stage;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stage <= '1;
    else
      stage <= {stage[sync_stages-2:0], pin};
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 1'b1;
    else if (stage[1] == stage[2])
      level <= stage[2];
  end
endmodule
`default_nettype wire
